// ### core/cbu_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// conditional branch unit
// ********************************************
module cbu_top #(
  parameter bit EXTENDED = 1'b0 // extended core variant
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // from fetch / execute
  input  wire logic        insn_valid_i,   // insn_i executes this cycle
  input  wire logic [23:0] insn_i,         // executing instruction
  input  wire logic [23:0] pc_i,           // its address
  input  wire logic [15:0] status_word_i,  // flags
  // to fetch / program counter
  output logic             pc_load_o,      // load pc_target_o
  output logic [23:0]      pc_target_o,    // branch target
  output logic             flush_o,        // replace fetched slot with nop
  output logic             stall_o,        // branch still busy
  output logic             branch_done_o,  // branch completed
  output logic             taken_o         // last branch was taken
);
  cbu_dec_if dif (); // decode results
  logic [1:0] cnt_ff;     // remaining extra cycles
  logic       busy;       // extra cycles in progress
  logic       accept;     // new branch accepted
  cbu_cond u_cond (
    .insn_i        (insn_i),
    .pc_i          (pc_i),
    .status_word_i (status_word_i),
    .dec           (dif.dec)
  );
  assign busy   = (cnt_ff != 2'h0);
  assign accept = insn_valid_i && dif.is_branch && !busy;
  // ********************************************
  // latency counter [RULE10] [RULE11]
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 2'h0;
    end else if (accept && dif.taken) begin
      cnt_ff <= EXTENDED ? cbu_pkg::TAKEN_EXTRA_EXT : cbu_pkg::TAKEN_EXTRA_BASE;
    end else if (busy) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end
  // ********************************************
  // pc load and flush; flags untouched [RULE13]
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pc_load_o   <= 1'b0;
      pc_target_o <= cbu_pkg::PC_RESET;
      flush_o     <= 1'b0;
      taken_o     <= 1'b0;
    end else begin
      pc_load_o <= accept && dif.taken;                  // [RULE6] [RULE12]
      flush_o   <= accept && dif.taken;                  // [RULE9]
      if (accept) begin
        pc_target_o <= dif.target;
        taken_o     <= dif.taken;
      end
    end
  end
  // ********************************************
  // stall and completion
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stall_o       <= 1'b0;
      branch_done_o <= 1'b0;
    end else begin
      // stall covers the extra cycles of a taken branch
      stall_o <= (accept && dif.taken) || (cnt_ff > 2'h1);
      // untaken: done next edge; taken: when count runs out
      branch_done_o <= (accept && !dif.taken) || (cnt_ff == 2'h1);
    end
  end
  // ********************************************
  // assertions
  // ********************************************
  // a taken branch accepted this cycle
  sequence s_take;
    accept && dif.taken;
  endsequence
  // base tail: one stall cycle, then done
  sequence s_base_tail;
    stall_o ##1 (branch_done_o && !stall_o);
  endsequence
  // extended tail: three stall cycles, then done
  sequence s_ext_tail;
    stall_o [*3] ##1 (branch_done_o && !stall_o);
  endsequence
  property p_flush_with_load;
    @(posedge clk_i) disable iff (!reset_n_i) flush_o == pc_load_o;
  endproperty
  a_flush_with_load: assert property (p_flush_with_load) // [RULE9]
    else $error("flush and pc load differ");
  property p_taken_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_take |=> pc_load_o && pc_target_o == $past(pc_i) + 24'h2
        + {{7{$past(insn_i[15])}}, $past(insn_i[15:0]), 1'b0};
  endproperty
  a_taken_load: assert property (p_taken_load) // [RULE6]
    else $error("wrong branch target");
  property p_untaken;
    @(posedge clk_i) disable iff (!reset_n_i)
      accept && !dif.taken |=> !pc_load_o && branch_done_o;
  endproperty
  a_untaken: assert property (p_untaken) // [RULE12]
    else $error("untaken branch redirected");
  property p_latency_base;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_take ##0 !EXTENDED |=> s_base_tail;
  endproperty
  a_latency_base: assert property (p_latency_base) // [RULE10]
    else $error("base taken latency wrong");
  property p_latency_ext;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_take ##0 EXTENDED |=> s_ext_tail;
  endproperty
  a_latency_ext: assert property (p_latency_ext) // [RULE11]
    else $error("extended taken latency wrong");
  property p_carry;
    @(posedge clk_i) disable iff (!reset_n_i)
      insn_i[23:16] == cbu_pkg::OPC_CARRY |-> dif.taken == status_word_i[0];
  endproperty
  a_carry: assert property (p_carry) // [RULE2]
    else $error("carry condition wrong");
  property p_sge;
    @(posedge clk_i) disable iff (!reset_n_i)
      insn_i[23:16] == cbu_pkg::OPC_SIGNED_GE
        |-> dif.taken == (status_word_i[3] == status_word_i[2]);
  endproperty
  a_sge: assert property (p_sge) // [RULE1]
    else $error("signed ge condition wrong");
  property p_sgt;
    @(posedge clk_i) disable iff (!reset_n_i)
      insn_i[23:16] == cbu_pkg::OPC_SIGNED_GT |-> dif.taken
        == (!status_word_i[1] && status_word_i[3] == status_word_i[2]);
  endproperty
  a_sgt: assert property (p_sgt) // [RULE4]
    else $error("signed gt condition wrong");
  property p_ugt;
    @(posedge clk_i) disable iff (!reset_n_i)
      insn_i[23:16] == cbu_pkg::OPC_UNS_GT
        |-> dif.taken == (status_word_i[0] && !status_word_i[1]);
  endproperty
  a_ugt: assert property (p_ugt) // [RULE5]
    else $error("unsigned gt condition wrong");
  // load and flush last a single cycle
  property p_load_pulse;
    @(posedge clk_i) disable iff (!reset_n_i)
      pc_load_o |=> !pc_load_o && !flush_o;
  endproperty
  a_load_pulse: assert property (p_load_pulse) // [RULE9]
    else $error("pc load held too long");
  // branches seen while busy leave target and load alone
  property p_busy_ignored;
    @(posedge clk_i) disable iff (!reset_n_i)
      busy |=> !pc_load_o && $stable(pc_target_o);
  endproperty
  a_busy_ignored: assert property (p_busy_ignored) // [RULE11]
    else $error("branch accepted while busy");
  // other opcodes never redirect or complete a branch
  property p_not_branch;
    @(posedge clk_i) disable iff (!reset_n_i)
      insn_valid_i && !dif.is_branch && !busy |=> !pc_load_o && !branch_done_o;
  endproperty
  a_not_branch: assert property (p_not_branch) // [RULE12]
    else $error("non-branch opcode acted on");
endmodule : cbu_top
`default_nettype wire

// ### include/cbu_pkg.sv
// Contract
// RULE1: opcode 0x3d branches when negative equals overflow
// RULE2: carry opcode branches only when carry set
// RULE3: unsigned ge shares 0x31 with carry branch
// RULE4: opcode 0x3c branches on zero clear, n equals ov
// RULE5: opcode 0x3e branches on carry set, zero clear
// RULE6: taken target is pc plus two plus offset
// RULE7: doubled offset is two's complement, both directions
// RULE8: offset is low 16 bits, signed words
// RULE9: taken branch flushes fetched slot with nop
// RULE10: base core: one cycle, two if taken
// RULE11: extended core: taken branch takes four cycles
// RULE12: untaken branch continues sequentially
// RULE13: flags never changed by branch
`default_nettype none
package cbu_pkg;
  // ********************************************
  // opcode upper bytes
  // ********************************************
  localparam logic [7:0] OPC_CARRY     = 8'h31; // carry / unsigned ge
  localparam logic [7:0] OPC_SIGNED_GT = 8'h3c; // signed greater than
  localparam logic [7:0] OPC_SIGNED_GE = 8'h3d; // signed greater or equal
  localparam logic [7:0] OPC_UNS_GT    = 8'h3e; // unsigned greater than
  // ********************************************
  // field layout
  // ********************************************
  localparam int INSN_W    = 24; // instruction word width
  localparam int PC_W      = 24; // program counter width
  localparam int OFS_W     = 16; // word offset width
  localparam int OPC_LSB   = 16; // opcode byte position
  localparam int FLAG_C    = 0;  // carry bit in status word
  localparam int FLAG_Z    = 1;  // zero bit
  localparam int FLAG_OV   = 2;  // overflow bit
  localparam int FLAG_N    = 3;  // negative bit
  localparam logic [PC_W-1:0] PC_STEP = 24'h000002; // next instruction
  localparam logic [INSN_W-1:0] NOP_WORD = 24'h000000; // flush word
  // ********************************************
  // timing
  // ********************************************
  localparam logic [1:0] TAKEN_EXTRA_BASE = 2'h1; // base: 2 cycles
  localparam logic [1:0] TAKEN_EXTRA_EXT  = 2'h3; // extended: 4 cycles
  localparam logic [PC_W-1:0] PC_RESET    = 24'h000000; // reset pc
  // decoded condition kinds
  typedef enum logic [2:0] {
    COND_NONE, COND_CARRY, COND_SGE, COND_SGT, COND_UGT
  } cbu_cond_e;
endpackage : cbu_pkg
`default_nettype wire

// ### include/cbu_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// decode result passed from condition decoder to branch unit core
interface cbu_dec_if;
  logic             is_branch; // opcode is a conditional branch
  logic             taken;     // condition holds
  logic [23:0]      target;    // computed target
  modport dec (output is_branch, output taken, output target);
  modport core (input is_branch, input taken, input target);
endinterface : cbu_dec_if
`default_nettype wire

// ### core/cbu_cond.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// condition decode and target compute
// ********************************************
module cbu_cond (
  // instruction and state
  input  wire logic [23:0] insn_i,
  input  wire logic [23:0] pc_i,
  input  wire logic [15:0] status_word_i,
  // result
  cbu_dec_if.dec           dec
);
  logic            n_f;   // negative
  logic            ov_f;  // overflow_flag
  logic            z_f;   // zero
  logic            c_f;   // carry
  cbu_pkg::cbu_cond_e kind; // decoded condition
  logic [23:0]     ofs_x; // doubled sign-extended offset
  assign n_f  = status_word_i[cbu_pkg::FLAG_N];
  assign ov_f = status_word_i[cbu_pkg::FLAG_OV];
  assign z_f  = status_word_i[cbu_pkg::FLAG_Z];
  assign c_f  = status_word_i[cbu_pkg::FLAG_C];
  // opcode decode
  always_comb begin
    case (insn_i[23:16])
      cbu_pkg::OPC_CARRY:     kind = cbu_pkg::COND_CARRY; // [RULE2] [RULE3]
      cbu_pkg::OPC_SIGNED_GE: kind = cbu_pkg::COND_SGE;   // [RULE1]
      cbu_pkg::OPC_SIGNED_GT: kind = cbu_pkg::COND_SGT;   // [RULE4]
      cbu_pkg::OPC_UNS_GT:    kind = cbu_pkg::COND_UGT;   // [RULE5]
      default:                kind = cbu_pkg::COND_NONE;
    endcase
  end
  // condition evaluation
  always_comb begin
    case (kind)
      cbu_pkg::COND_CARRY: dec.taken = c_f;                    // [RULE2]
      cbu_pkg::COND_SGE:   dec.taken = (n_f == ov_f);          // [RULE1]
      cbu_pkg::COND_SGT:   dec.taken = !z_f && (n_f == ov_f);  // [RULE4]
      cbu_pkg::COND_UGT:   dec.taken = c_f && !z_f;            // [RULE5]
      default:             dec.taken = 1'b0;
    endcase
  end
  assign dec.is_branch = (kind != cbu_pkg::COND_NONE);
  // signed word offset, doubled, sign-extended [RULE7] [RULE8]
  assign ofs_x = {{7{insn_i[15]}}, insn_i[15:0], 1'b0};
  assign dec.target = pc_i + cbu_pkg::PC_STEP + ofs_x; // [RULE6]
endmodule : cbu_cond
`default_nettype wire

// ### testbench/cbu_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// fetch and program counter partner
// ********************************************
module cbu_fetch_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // from branch unit
  input  wire logic        pc_load_i,
  input  wire logic [23:0] target_i,
  input  wire logic        flush_i,
  // observed state
  output logic      [23:0] pc_o,
  output logic      [23:0] slot_o
);
  // pc: load on branch, else step one word
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) pc_o <= cbu_pkg::PC_RESET;
    else if (pc_load_i) pc_o <= target_i;
    else pc_o <= pc_o + cbu_pkg::PC_STEP;
  end
  // fetched slot: nop on flush, else a changing pattern
  always_ff @(posedge clk_i) begin
    slot_o <= flush_i ? cbu_pkg::NOP_WORD : ~pc_o;
  end
endmodule // cbu_fetch_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********************************************
  // signals
  // ********************************************
  logic        clk_i;         // core clock
  logic        reset_n_i;     // sync reset
  logic        insn_valid_i;  // request
  logic [23:0] insn_i;        // instruction
  logic [23:0] pc_i;          // its address
  logic [15:0] status_word_i; // flags
  wire logic [1:0]  ld, fl, st, dn, tk; // bit v: variant v
  wire logic [23:0] tgt [2];  // targets per variant
  logic [23:0] f_pc, f_slot;  // partner state
  int          failures;      // mismatches
  int          num_checks;    // compares
  // clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // base and extended variants side by side
  for (genvar v = 0; v < 2; v++) begin : g_var
    cbu_top #(.EXTENDED(v == 1)) cbu_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .insn_valid_i(insn_valid_i), .insn_i(insn_i), .pc_i(pc_i),
      .status_word_i(status_word_i), .pc_load_o(ld[v]), .pc_target_o(tgt[v]),
      .flush_o(fl[v]), .stall_o(st[v]), .branch_done_o(dn[v]), .taken_o(tk[v]));
  end
  cbu_fetch_model cbu_fetch_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pc_load_i(ld[0]), .target_i(tgt[0]), .flush_i(fl[0]), .pc_o(f_pc), .slot_o(f_slot));
  // ********************************************
  // shared tasks
  // ********************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one branch, then four cycles of watching
  task automatic br(input logic [7:0] op, input logic [15:0] sw, input logic [23:0] pc,
                    input logic [15:0] ofs, input logic t);
    logic [23:0] e;
    e = pc + 24'h000002 + {{7{ofs[15]}}, ofs, 1'b0};
    insn_valid_i = 1'b1;
    insn_i = {op, ofs};
    pc_i = pc;
    status_word_i = sw;
    @(posedge clk_i);
    #1;
    insn_valid_i = 1'b0;
    chk(24'(tk), {22'h0, t, t});
    chk(24'({ld, fl, st, dn}), 24'({t, t, t, t, t, t, ~t, ~t}));
    if (t) chk(tgt[0], e);
    if (t) chk(tgt[1], e);
    for (int k = 2; k <= 4; k++) begin
      @(posedge clk_i);
      #1;
      chk(24'({dn, st}), 24'({t && k == 4, t && k == 2, t && k < 4, 1'b0}));
      chk(24'({ld, fl}), 24'h000000);
      if (t && k == 2) chk(f_pc, e);
      if (t && k == 2) chk(f_slot, cbu_pkg::NOP_WORD);
    end
  endtask
  // ********************************************
  // scenarios
  // ********************************************
  task automatic t_carry;
    br(8'h31, 16'h0001, 24'h002000, 16'h0003, 1'b1);
    br(8'h31, 16'h000e, 24'h002000, 16'h0003, 1'b0);
  endtask
  task automatic t_sge;
    br(8'h3d, 16'h0000, 24'h007608, 16'hfffb, 1'b1);
    br(8'h3d, 16'h000c, 24'h007608, 16'hfffb, 1'b1);
    br(8'h3d, 16'h0008, 24'h007608, 16'hfffb, 1'b0);
  endtask
  task automatic t_sgt;
    br(8'h3c, 16'h000c, 24'h002000, 16'h0005, 1'b1);
    br(8'h3c, 16'h0002, 24'h002000, 16'h0005, 1'b0);
    br(8'h3c, 16'h0004, 24'h002000, 16'h0005, 1'b0);
  endtask
  task automatic t_ugt;
    br(8'h3e, 16'h0001, 24'h002000, 16'h0005, 1'b1);
    br(8'h3e, 16'h0003, 24'h002000, 16'h0005, 1'b0);
    br(8'h3e, 16'h0000, 24'h002000, 16'h0005, 1'b0);
  endtask
  task automatic t_offset;
    br(8'h31, 16'h0001, 24'h00623c, 16'hfffb, 1'b1);
    br(8'h31, 16'h0001, 24'h010000, 16'h8000, 1'b1);
    br(8'h31, 16'h0001, 24'h000100, 16'h7fff, 1'b1);
  endtask
  // taken branch held over the busy edge: second copy refused
  task automatic t_busy;
    insn_valid_i = 1'b1;
    insn_i = {8'h3d, 16'h0001};
    pc_i = 24'h003000;
    status_word_i = 16'h0000;
    repeat (2) @(posedge clk_i);
    #1;
    insn_valid_i = 1'b0;
    chk(24'({ld, fl, st, dn}), 24'h000009);
    repeat (2) @(posedge clk_i);
    #1;
    chk(24'({st, dn}), 24'h000002);
  endtask
  // foreign opcode, then a branch without valid: both ignored
  task automatic t_other;
    insn_valid_i = 1'b1;
    insn_i = {8'h37, 16'h0004};
    pc_i = 24'h002000;
    status_word_i = 16'h000f;
    @(posedge clk_i);
    #1;
    chk(24'({ld, fl, st, dn}), 24'h000000);
    insn_valid_i = 1'b0;
    insn_i = {8'h3d, 16'h0004};
    status_word_i = 16'h0000;
    @(posedge clk_i);
    #1;
    chk(24'({ld, fl, st, dn}), 24'h000000);
  endtask
  // reset in mid branch clears the count; next branch accepted at once
  task automatic t_reset_mid;
    insn_valid_i = 1'b1;
    insn_i = {8'h31, 16'h0003};
    pc_i = 24'h002000;
    status_word_i = 16'h0001;
    @(posedge clk_i);
    #1;
    insn_valid_i = 1'b0;
    reset_n_i = 1'b0;
    @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    chk(24'({ld, fl, st, dn, tk}), 24'h000000);
    br(8'h3e, 16'h0001, 24'h002000, 16'h0005, 1'b1);
  endtask
  task automatic final_report;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    insn_valid_i = 1'b0;
    insn_i = 24'h000000;
    pc_i = 24'h000000;
    status_word_i = 16'h0000;
    repeat (6) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    chk(24'({ld, fl, st, dn, tk}), 24'h000000);
    t_carry();
    t_sge();
    t_sgt();
    t_ugt();
    t_offset();
    t_busy();
    t_other();
    t_reset_mid();
    final_report();
  end
  // watchdog
  initial begin
    #(40 * 400);
    failures++;
    final_report();
  end
endmodule // tb
`default_nettype wire
